// [include/osc_switch_failsafe_ctrl_regs.vh]
/*
  Constants of the oscillator switch and fail-safe control block: register
  offsets, field positions, reset values, group codes and timing counts.
  Assumes a 40 MHz ref_clk and 32-bit Avalon-MM access with byte addresses.
*/
// Overview of operation
// - PLL multiplies primary clock by four, eight, sixteen
// - PLL lock mirrored in read-only status bit
// - current group 01 selects the fast RC
// - four-bit signed trim, 1.5 percent per count
// - low-power RC on until powerup timer, then conditional
// - monitor enabled keeps low-power RC on except Sleep
// - oscillator failure traps and moves to fast RC
// - failure loads current group, sets fail flag, clears go
// - clock failure leaves the watchdog clock running
// - timer expiry before oscillator start traps to fast RC
// - switch only between groups; primary choice from fuses
// - current group read-only; fields load from fuses
// - go bit starts switch; clearing it aborts
// - configuration 1x disables switching and monitor
// - switching disabled means fuses select the clock directly
// - low byte unlocked by keys 0x46 then 0x57
// - high byte unlocked by keys 0x78 then 0x9A
// - reset held for bias plus 0/4/16/64 ms delay
// - reset released on next quarter-clock leading edge
// - internal resets never drive master clear low
// - master clear path filters short noise pulses
// - lock at bit 5; clock held until locked
// - start-up timer counts 1024 oscillator cycles
`ifndef OSC_SWITCH_FAILSAFE_CTRL_REGS_VH
`define OSC_SWITCH_FAILSAFE_CTRL_REGS_VH

// register byte offsets
`define OFS_CLOCK_SELECT 4'h0
`define OFS_STATUS 4'h4
`define OFS_CONTROL 4'h8

// clock_select_register fields and control register soft watchdog bit
`define BIT_SWITCH_GO 0
`define BIT_CLOCK_FAIL 3
`define BIT_PLL_LOCK 5
`define POS_NEW_GROUP 8
`define POS_TRIM_LO 10
`define POS_CUR_GROUP 12
`define POS_TRIM_HI 14
`define BIT_SOFT_WDT 0

// reset values
`define RST_TRIM 4'h0
`define RST_CONTROL 1'b0

// unlock keys
`define KEY_LOW_1 8'h46
`define KEY_LOW_2 8'h57
`define KEY_HIGH_1 8'h78
`define KEY_HIGH_2 8'h9A

// group codes
`define GRP_SECONDARY 2'b00
`define GRP_FAST_RC 2'b01
`define GRP_LOW_RC 2'b10
`define GRP_PRIMARY 2'b11

// timing
`define CLK_MHZ 40
`define BIAS_DELAY_NS 10000
`define BIAS_CYCLES ((`BIAS_DELAY_NS * `CLK_MHZ + 999) / 1000)
`define POWERUP_TIMER_SHORT_MS 4
`define POWERUP_TIMER_MID_MS 16
`define POWERUP_TIMER_LONG_MS 64
`define CYCLES_PER_MS (`CLK_MHZ * 1000)
`define OST_COUNT 1024
`define MASTER_CLEAR_PIN_FILTER_CYCLES 8

`endif

// [hdl/osc_switch_failsafe_ctrl.v]
/*
  Oscillator switch, fail-safe monitor and power-up reset sequencer with an
  Avalon-MM register slave. Assumes all inputs are synchronous to ref_clk,
  and that oscillator ticks, quarter-clock marks and events are one-cycle pulses.
*/
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`include "osc_switch_failsafe_ctrl_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module osc_switch_failsafe_ctrl #(
  parameter POWERUP_TIMER_SHORT_CYCLES = `POWERUP_TIMER_SHORT_MS * `CYCLES_PER_MS,
  parameter POWERUP_TIMER_MID_CYCLES   = `POWERUP_TIMER_MID_MS * `CYCLES_PER_MS,
  parameter POWERUP_TIMER_LONG_CYCLES  = `POWERUP_TIMER_LONG_MS * `CYCLES_PER_MS
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        arst_n,
  // avalon-mm slave
  input  wire [3:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  // configuration fuses
  input  wire [1:0]  groupCfg,
  input  wire [3:0]  primaryChoiceCfg,
  input  wire [1:0]  switchMonitorCfg,
  input  wire [1:0]  powerupDelayCfg,
  input  wire        watchdogFuse,
  // oscillator and system events
  input  wire        pllLock,
  input  wire        oscTick,
  input  wire        oscFail,
  input  wire [3:0]  groupReady,
  input  wire        quarterClock,
  input  wire        brownOut,
  input  wire        wakeUp,
  input  wire        sleepMode,
  input  wire        masterClearN,
  // clock control outputs
  output reg  [1:0]  sysClkGroup,
  output reg  [1:0]  switchTarget,
  output reg         switchBusy,
  output reg         pllEnable,
  output reg  [1:0]  pllMult,
  output reg  [3:0]  fastRcTrim,
  output reg  [7:0]  trimOffset,
  output reg         lowRcEnable,
  output reg         watchdogClkEnable,
  output reg         clockHold,
  output reg         clockFailTrap,
  output reg         internalResetN,
  // master clear pin drive
  output reg         masterClearOut,
  output reg         masterClearOeN
);

  ////////////////////////////////////////////////////////////////////////////
  // local codes

  localparam [2:0] K_IDLE = 3'd0;
  localparam [2:0] K_LO1  = 3'd1;
  localparam [2:0] K_LOG  = 3'd2;
  localparam [2:0] K_HI1  = 3'd3;
  localparam [2:0] K_HIG  = 3'd4;

  localparam [1:0] S_BIAS = 2'd0;
  localparam [1:0] S_POWERUP_TIMER = 2'd1;
  localparam [1:0] S_WAIT = 2'd2;
  localparam [1:0] S_RUN  = 2'd3;

  // 1.5 percent steps in tenths of a percent
  function [7:0] trimTenths;
    input [3:0] code;
    begin
      trimTenths = {{4{code[3]}}, code} * 8'h0F;
    end
  endfunction

  // multiplier code for a primary choice, zero when no pll
  function [1:0] pllCode;
    input [3:0] primary_choice_cfg;
    begin
      if (primary_choice_cfg[2] && primary_choice_cfg[1:0] != 2'b00)
        pllCode = primary_choice_cfg[1:0];
      else
        pllCode = 2'b00;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg  [1:0]  curGroup_reg;
  reg  [1:0]  newGroup_reg;
  reg  [3:0]  trim_reg;
  reg         clockFail_reg;
  reg         switchGo_reg;
  reg         lock_reg;
  reg         softWdt_reg;
  reg  [2:0]  keyState_reg;
  reg         fuseLoad_reg;
  reg  [1:0]  rstState_reg;
  reg  [21:0] rstCnt_reg;
  reg         pwrtDone_reg;
  reg  [9:0]  ostCnt_reg;
  reg         ostDone_reg;
  reg  [3:0]  mclrCnt_reg;
  reg         mclrActive_reg;

  wire        switchEn  = ~switchMonitorCfg[1];
  wire        monitorEn = switchMonitorCfg == 2'b00;
  wire        access    = (read | write) & ~waitrequest;
  wire        wrSel     = write & ~waitrequest & (address[3:2] == 2'd0);
  wire        loByteKey = wrSel & (byteenable == 4'b0001);
  wire        hiByteKey = wrSel & (byteenable == 4'b0010);
  wire        loGrant   = wrSel & byteenable[0] & (keyState_reg == K_LOG);
  wire        hiGrant   = wrSel & byteenable[1] & (keyState_reg == K_HIG);
  wire        crystal   = (curGroup_reg == `GRP_SECONDARY) ||
                          (curGroup_reg == `GRP_PRIMARY && ~primaryChoiceCfg[3]);
  wire        pllUsed   = (curGroup_reg == `GRP_PRIMARY) &&
                          (pllCode(primaryChoiceCfg) != 2'b00);
  wire        oscReady  = (~crystal | ostDone_reg) & (~pllUsed | lock_reg);
  wire        pwrtExpire;
  wire        failEvent;
  wire [21:0] pwrtLimit;
  wire [15:0] clockSelect;

  assign pwrtLimit = (powerupDelayCfg == 2'd1) ? POWERUP_TIMER_SHORT_CYCLES[21:0] :
                     (powerupDelayCfg == 2'd2) ? POWERUP_TIMER_MID_CYCLES[21:0] :
                     POWERUP_TIMER_LONG_CYCLES[21:0];

  assign pwrtExpire = (rstState_reg == S_POWERUP_TIMER && rstCnt_reg == pwrtLimit - 22'd1) ||
                      (rstState_reg == S_BIAS && powerupDelayCfg == 2'd0 &&
                       rstCnt_reg == `BIAS_CYCLES - 1);

  // oscillator failure, or timer ran out before the oscillator started
  assign failEvent = monitorEn & ~fuseLoad_reg & curGroup_reg != `GRP_FAST_RC &
                     ((oscFail & pwrtDone_reg) |
                      (pwrtExpire & ~oscReady & (curGroup_reg == `GRP_PRIMARY ||
                       curGroup_reg == `GRP_SECONDARY)));

  assign clockSelect = {trim_reg[3:2], curGroup_reg, trim_reg[1:0], newGroup_reg,
                        2'b00, lock_reg, 1'b0, clockFail_reg, 2'b00,
                        switchGo_reg};

  ////////////////////////////////////////////////////////////////////////////
  // avalon handshake and read data

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
      if (read & waitrequest) begin
        case (address[3:2])
          2'd0: readdata <= {16'h0000, clockSelect};
          2'd1: readdata <= {24'h00_0000, pllMult, sysClkGroup, lowRcEnable,
                             ostDone_reg, pwrtDone_reg, ~internalResetN};
          2'd2: readdata <= {31'h0000_0000, softWdt_reg};
          default: readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequencer, any other access discards a partial sequence

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      keyState_reg <= K_IDLE;
    end else if (access) begin
      case (keyState_reg)
        K_IDLE, K_LOG, K_HIG: begin
          if (loByteKey && writedata[7:0] == `KEY_LOW_1)
            keyState_reg <= K_LO1;
          else if (hiByteKey && writedata[15:8] == `KEY_HIGH_1)
            keyState_reg <= K_HI1;
          else
            keyState_reg <= K_IDLE;
        end
        K_LO1: begin
          if (loByteKey && writedata[7:0] == `KEY_LOW_2)
            keyState_reg <= K_LOG;
          else
            keyState_reg <= K_IDLE;
        end
        K_HI1: begin
          if (hiByteKey && writedata[15:8] == `KEY_HIGH_2)
            keyState_reg <= K_HIG;
          else
            keyState_reg <= K_IDLE;
        end
        default: keyState_reg <= K_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock select register and group switching

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fuseLoad_reg  <= 1'b1;
      curGroup_reg  <= `GRP_FAST_RC;
      newGroup_reg  <= `GRP_FAST_RC;
      trim_reg      <= `RST_TRIM;
      clockFail_reg <= 1'b0;
      switchGo_reg  <= 1'b0;
      switchBusy    <= 1'b0;
      switchTarget  <= `GRP_FAST_RC;
      lock_reg      <= 1'b0;
      softWdt_reg   <= `RST_CONTROL;
      clockFailTrap <= 1'b0;
    end else begin
      fuseLoad_reg  <= 1'b0;
      lock_reg      <= pllLock;
      clockFailTrap <= failEvent;
      if (write & ~waitrequest & address[3:2] == 2'd2 & byteenable[0])
        softWdt_reg <= writedata[`BIT_SOFT_WDT];
      if (hiGrant) begin
        trim_reg[3:2] <= writedata[`POS_TRIM_HI +: 2];
        trim_reg[1:0] <= writedata[`POS_TRIM_LO +: 2];
        newGroup_reg  <= writedata[`POS_NEW_GROUP +: 2];
      end
      if (loGrant) begin
        switchGo_reg <= writedata[`BIT_SWITCH_GO];
        if (!writedata[`BIT_CLOCK_FAIL])
          clockFail_reg <= 1'b0;
      end
      if (fuseLoad_reg || brownOut) begin
        curGroup_reg <= groupCfg;
        newGroup_reg <= groupCfg;
        switchGo_reg <= 1'b0;
        switchBusy   <= 1'b0;
      end else if (failEvent) begin
        curGroup_reg  <= `GRP_FAST_RC;
        clockFail_reg <= 1'b1;
        switchGo_reg  <= 1'b0;
        switchBusy    <= 1'b0;
      end else if (!switchEn) begin
        curGroup_reg <= groupCfg;
        switchGo_reg <= 1'b0;
        switchBusy   <= 1'b0;
      end else if (switchBusy) begin
        if (!switchGo_reg || (loGrant && !writedata[`BIT_SWITCH_GO])) begin
          switchBusy   <= 1'b0;
          switchGo_reg <= 1'b0;
        end else if (groupReady[switchTarget]) begin
          curGroup_reg <= switchTarget;
          switchBusy   <= 1'b0;
          switchGo_reg <= 1'b0;
        end
      end else if (switchGo_reg && !loGrant) begin
        if (newGroup_reg == curGroup_reg) begin
          switchGo_reg <= 1'b0;
        end else begin
          switchBusy   <= 1'b1;
          switchTarget <= newGroup_reg;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-up reset sequencer and master clear filter

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstState_reg   <= S_BIAS;
      rstCnt_reg     <= 22'h00_0000;
      pwrtDone_reg   <= 1'b0;
      internalResetN <= 1'b0;
      mclrCnt_reg    <= 4'h0;
      mclrActive_reg <= 1'b0;
    end else begin
      if (masterClearN == mclrActive_reg) begin
        if (mclrCnt_reg == `MASTER_CLEAR_PIN_FILTER_CYCLES - 1) begin
          mclrActive_reg <= ~masterClearN;
          mclrCnt_reg    <= 4'h0;
        end else begin
          mclrCnt_reg <= mclrCnt_reg + 4'h1;
        end
      end else begin
        mclrCnt_reg <= 4'h0;
      end
      if (brownOut) begin
        rstState_reg   <= S_BIAS;
        rstCnt_reg     <= 22'h00_0000;
        pwrtDone_reg   <= 1'b0;
        internalResetN <= 1'b0;
      end else begin
        case (rstState_reg)
          S_BIAS: begin
            if (rstCnt_reg == `BIAS_CYCLES - 1) begin
              rstCnt_reg <= 22'h00_0000;
              if (powerupDelayCfg == 2'd0) begin
                rstState_reg <= S_WAIT;
                pwrtDone_reg <= 1'b1;
              end else begin
                rstState_reg <= S_POWERUP_TIMER;
              end
            end else begin
              rstCnt_reg <= rstCnt_reg + 22'h00_0001;
            end
          end
          S_POWERUP_TIMER: begin
            if (pwrtExpire) begin
              rstState_reg <= S_WAIT;
              pwrtDone_reg <= 1'b1;
              rstCnt_reg   <= 22'h00_0000;
            end else begin
              rstCnt_reg <= rstCnt_reg + 22'h00_0001;
            end
          end
          S_WAIT: begin
            if (quarterClock && !mclrActive_reg) begin
              rstState_reg   <= S_RUN;
              internalResetN <= 1'b1;
            end
          end
          S_RUN: begin
            if (mclrActive_reg) begin
              rstState_reg   <= S_WAIT;
              internalResetN <= 1'b0;
            end
          end
          default: rstState_reg <= S_BIAS;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator start-up timer

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ostCnt_reg  <= 10'h000;
      ostDone_reg <= 1'b0;
    end else if (brownOut || wakeUp || fuseLoad_reg) begin
      ostCnt_reg  <= 10'h000;
      ostDone_reg <= 1'b0;
    end else if (oscTick && !ostDone_reg) begin
      ostCnt_reg <= ostCnt_reg + 10'h001;
      if (ostCnt_reg == `OST_COUNT - 1)
        ostDone_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock outputs

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sysClkGroup       <= `GRP_FAST_RC;
      pllEnable         <= 1'b0;
      pllMult           <= 2'b00;
      fastRcTrim        <= `RST_TRIM;
      trimOffset        <= 8'h00;
      lowRcEnable       <= 1'b1;
      watchdogClkEnable <= 1'b0;
      clockHold         <= 1'b1;
      masterClearOut    <= 1'b1;
      masterClearOeN    <= 1'b1;
    end else begin
      sysClkGroup <= switchEn ? curGroup_reg : groupCfg;
      pllMult     <= pllCode(primaryChoiceCfg);
      pllEnable   <= pllUsed;
      fastRcTrim  <= trim_reg;
      trimOffset  <= trimTenths(trim_reg);
      clockHold   <= ~oscReady;
      if (!pwrtDone_reg)
        lowRcEnable <= 1'b1;
      else if (monitorEn)
        lowRcEnable <= ~sleepMode | watchdogFuse;
      else
        lowRcEnable <= watchdogFuse | softWdt_reg |
                       curGroup_reg == `GRP_LOW_RC;
      // failure events never touch the watchdog clock
      watchdogClkEnable <= watchdogFuse | (softWdt_reg & ~monitorEn);
      masterClearOut    <= 1'b1;
      masterClearOeN    <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// [bench/osc_switch_failsafe_ctrl_asserts.sv]
/*
  Port-level checker of the oscillator switch and fail-safe block.
  Assumes one clock domain, ref_clk, with arst_n as its reset.
*/
`timescale 1ns/1ps
`default_nettype none
module osc_switch_failsafe_ctrl_asserts (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       arst_n,
  // bus
  input wire logic       read,
  input wire logic       write,
  input wire logic       waitrequest,
  // fuses and events
  input wire logic [1:0] switchMonitorCfg,
  input wire logic       oscFail,
  input wire logic       quarterClock,
  input wire logic       sleepMode,
  input wire logic       masterClearN,
  // outputs
  input wire logic [1:0] sysClkGroup,
  input wire logic       switchBusy,
  input wire logic       lowRcEnable,
  input wire logic       clockFailTrap,
  input wire logic       internalResetN,
  input wire logic       masterClearOut,
  input wire logic       masterClearOeN
);
  logic [15:0] sinceRst;
  logic [4:0]  mclrLow;
  // cycles since release, low run of the pin
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sinceRst <= 16'h0000;
      mclrLow <= 5'h00;
    end else begin
      sinceRst <= (sinceRst == 16'hffff) ? sinceRst : sinceRst + 16'h0001;
      mclrLow <= masterClearN ? 5'h00 : ((mclrLow == 5'h1f) ? mclrLow : mclrLow + 5'h01);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////
  bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  bus_wait_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  fail_trap_a: assert property (oscFail && switchMonitorCfg == 2'b00 |-> ##[1:3] clockFailTrap)
    else $error("no trap after failure");
  fail_group_a: assert property (oscFail && switchMonitorCfg == 2'b00 |-> ##[1:4] sysClkGroup == 2'b01)
    else $error("no move to fast rc");
  monitor_off_a: assert property (switchMonitorCfg[1] |-> !clockFailTrap && !switchBusy)
    else $error("switch or monitor active while off");
  low_power_internal_rc_kept_a: assert property (switchMonitorCfg == 2'b00 && !sleepMode && !$past(sleepMode) |-> lowRcEnable)
    else $error("low rc off with monitor on");
  low_power_internal_rc_powerup_a: assert property (!internalResetN && sinceRst < 16'h0190 |-> lowRcEnable)
    else $error("low rc off during power-up");
  release_q1_a: assert property ($rose(internalResetN) |-> $past(quarterClock) || $past(quarterClock, 2))
    else $error("reset release off quarter clock");
  bias_delay_a: assert property ($rose(internalResetN) |-> sinceRst >= 16'h0190)
    else $error("reset released before bias delay");
  master_clear_pin_filter_a: assert property ($fell(internalResetN) |-> mclrLow >= 5'h06)
    else $error("short master clear pulse passed");
  pin_released_a: assert property (masterClearOeN && masterClearOut)
    else $error("master clear pin driven");
endmodule
bind osc_switch_failsafe_ctrl osc_switch_failsafe_ctrl_asserts chk (
  .ref_clk(ref_clk), .arst_n(arst_n), .read(read), .write(write),
  .waitrequest(waitrequest), .switchMonitorCfg(switchMonitorCfg), .oscFail(oscFail),
  .quarterClock(quarterClock), .sleepMode(sleepMode), .masterClearN(masterClearN),
  .sysClkGroup(sysClkGroup), .switchBusy(switchBusy), .lowRcEnable(lowRcEnable),
  .clockFailTrap(clockFailTrap), .internalResetN(internalResetN),
  .masterClearOut(masterClearOut), .masterClearOeN(masterClearOeN));
`default_nettype wire

// [bench/osc_switch_failsafe_ctrl_bench.sv]
/*
  Self-checking bench of the oscillator switch block: power-up timing, PLL,
  trim unlock, switching, fail-safe and master clear filter.
  Assumes the design and its checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module osc_switch_failsafe_ctrl_bench;
  logic        ref_clk, arst_n, read, write, waitrequest, watchdogFuse, pllLock;
  logic        oscTick, oscFail, quarterClock, brownOut, wakeUp, sleepMode;
  logic        masterClearN, switchBusy, pllEnable, lowRcEnable, watchdogClkEnable;
  logic        clockHold, clockFailTrap, internalResetN, masterClearOut, masterClearOeN, w;
  logic [3:0]  address, byteenable, primaryChoiceCfg, groupReady, fastRcTrim, v, pri;
  logic [31:0] writedata, readdata, rd, seed;
  logic [1:0]  groupCfg, switchMonitorCfg, powerupDelayCfg, sysClkGroup, switchTarget;
  logic [1:0]  pllMult, qc = 2'h0;
  logic [7:0]  trimOffset;
  int          num_errors, comparisons, cycles, n, k, i;
  osc_switch_failsafe_ctrl #(.POWERUP_TIMER_SHORT_CYCLES(20), .POWERUP_TIMER_MID_CYCLES(40),
    .POWERUP_TIMER_LONG_CYCLES(80)) dut (.ref_clk(ref_clk), .arst_n(arst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .groupCfg(groupCfg),
    .primaryChoiceCfg(primaryChoiceCfg), .switchMonitorCfg(switchMonitorCfg),
    .powerupDelayCfg(powerupDelayCfg), .watchdogFuse(watchdogFuse), .pllLock(pllLock),
    .oscTick(oscTick), .oscFail(oscFail), .groupReady(groupReady),
    .quarterClock(quarterClock), .brownOut(brownOut), .wakeUp(wakeUp),
    .sleepMode(sleepMode), .masterClearN(masterClearN), .sysClkGroup(sysClkGroup),
    .switchTarget(switchTarget), .switchBusy(switchBusy), .pllEnable(pllEnable),
    .pllMult(pllMult), .fastRcTrim(fastRcTrim), .trimOffset(trimOffset),
    .lowRcEnable(lowRcEnable), .watchdogClkEnable(watchdogClkEnable),
    .clockHold(clockHold), .clockFailTrap(clockFailTrap),
    .internalResetN(internalResetN), .masterClearOut(masterClearOut),
    .masterClearOeN(masterClearOeN));
  ////////////////////////////////////////////////////////////////////////////
  // trim in signed tenths of a percent
  function automatic logic [7:0] pct(input logic [3:0] c);
    logic signed [7:0] s;
    s = {{4{c[3]}}, c};
    return s * 8'sh0f;
  endfunction
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one avalon access, held until waitrequest low
  task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge ref_clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // two keys then a value on one byte lane of word 0
  task automatic uw(input bit hi, input logic [7:0] k1, input logic [7:0] k2,
                    input logic [7:0] val);
    bus(1'b1, 4'h0, hi ? {16'h0000, k1, 8'h00} : {24'h00_0000, k1}, hi ? 4'h2 : 4'h1);
    bus(1'b1, 4'h0, hi ? {16'h0000, k2, 8'h00} : {24'h00_0000, k2}, hi ? 4'h2 : 4'h1);
    bus(1'b1, 4'h0, hi ? {16'h0000, val, 8'h00} : {24'h00_0000, val}, hi ? 4'h2 : 4'h1);
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic reset_dut(input logic [1:0] g, input logic [3:0] p,
                           input logic [1:0] s, input logic [1:0] d);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    groupCfg <= g;
    primaryChoiceCfg <= p;
    switchMonitorCfg <= s;
    powerupDelayCfg <= d;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    n = 0;
    while (internalResetN !== 1'b1) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // quarter-clock marks and hang limit
  always @(posedge ref_clk) begin
    qc <= qc + 2'h1;
    quarterClock <= (qc == 2'h3);
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      $display("unexpected at %0t: run timed out", $time);
      close_out;
    end
  end
  initial begin
    seed = 32'h6691_fcce;
    {arst_n, read, write, watchdogFuse, pllLock, oscFail} = 6'h00;
    {brownOut, wakeUp, sleepMode, address, byteenable, writedata} = 43'h0;
    {groupCfg, primaryChoiceCfg, switchMonitorCfg, powerupDelayCfg} = 10'h0;
    {oscTick, masterClearN, groupReady} = 6'h3f;
    for (k = 0; k < 4; k++) begin
      pllLock <= 1'b0;
      pri = (k == 0) ? 4'h4 : {2'b01, k[1:0]};
      reset_dut(2'b11, pri, 2'b10, k[1:0]);
      `CHK(n >= 398 + ((k == 0) ? 0 : (10 << k)) && n <= 410 + ((k == 0) ? 0 : (10 << k)), 1'b1)
      `CHK(pllEnable, k != 0)
      `CHK(pllMult, k[1:0])
      `CHK(sysClkGroup, 2'b11)
      bus(1'b0, 4'h0, 32'h0000_0000, 4'hf);
      `CHK(rd[13:12], 2'b11)
      `CHK(rd[9:8], 2'b11)
      `CHK(rd[5], 1'b0)
      repeat (850 - n) @(posedge ref_clk);
      `CHK(clockHold, 1'b1)
      pllLock <= 1'b1;
      repeat (250) @(posedge ref_clk);
      `CHK(clockHold, 1'b0)
      bus(1'b0, 4'h0, 32'h0000_0000, 4'hf);
      `CHK(rd[5], 1'b1)
    end
    `CHK(lowRcEnable, 1'b0)
    watchdogFuse <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK(lowRcEnable, 1'b1)
    watchdogFuse <= 1'b0;
    bus(1'b1, 4'h8, 32'h0000_0001, 4'hf);
    repeat (2) @(posedge ref_clk);
    `CHK(lowRcEnable, 1'b1)
    bus(1'b1, 4'h8, 32'h0000_0000, 4'hf);
    bus(1'b0, 4'hc, 32'h0000_0000, 4'hf);
    `CHK(rd, 32'h0000_0000)
    pllLock <= 1'b0;
    repeat (2) @(posedge ref_clk);
    bus(1'b0, 4'h0, 32'h0000_0000, 4'hf);
    `CHK(rd[5], 1'b0)
    $display("power-up and pll test done");
    pllLock <= 1'b1;
    groupReady <= 4'h0;
    reset_dut(2'b11, 4'h4, 2'b00, 2'b01);
    repeat (4) @(posedge ref_clk);
    `CHK(sysClkGroup, 2'b01)
    bus(1'b0, 4'h0, 32'h0000_0000, 4'hf);
    `CHK(rd[13:12], 2'b01)
    `CHK(rd[3], 1'b1)
    for (i = 0; i < 6; i++) begin
      v = (i == 0) ? 4'h7 : (i == 1) ? 4'h8 : (i == 2) ? 4'h0 : 4'($random(seed));
      uw(1'b1, 8'h78, 8'h9a, {v[3:2], 2'b00, v[1:0], 2'b01});
      `CHK(fastRcTrim, v)
      `CHK(trimOffset, pct(v))
      bus(1'b0, 4'h0, 32'h0000_0000, 4'hf);
      `CHK({rd[15:14], rd[11:10]}, v)
    end
    bus(1'b1, 4'h0, 32'h0000_0000, 4'h2);
    uw(1'b1, 8'h46, 8'h57, 8'h00);
    uw(1'b1, 8'h9a, 8'h78, 8'h00);
    bus(1'b1, 4'h0, 32'h0000_7800, 4'h2);
    bus(1'b0, 4'h0, 32'h0000_0000, 4'hf);
    bus(1'b1, 4'h0, 32'h0000_9a00, 4'h2);
    bus(1'b1, 4'h0, 32'h0000_0000, 4'h2);
    `CHK(fastRcTrim, v)
    bus(1'b0, 4'h0, 32'h0000_0000, 4'hf);
    `CHK(rd[9:8], 2'b01)
    $display("trim and unlock test done");
    uw(1'b1, 8'h78, 8'h9a, {v[3:2], 2'b00, v[1:0], 2'b10});
    uw(1'b0, 8'h46, 8'h57, 8'h01);
    `CHK(switchBusy, 1'b1)
    `CHK(switchTarget, 2'b10)
    uw(1'b0, 8'h46, 8'h57, 8'h00);
    `CHK(switchBusy, 1'b0)
    `CHK(sysClkGroup, 2'b01)
    uw(1'b0, 8'h46, 8'h57, 8'h01);
    groupReady <= 4'hf;
    repeat (6) @(posedge ref_clk);
    `CHK(sysClkGroup, 2'b10)
    `CHK(lowRcEnable, 1'b1)
    bus(1'b0, 4'h0, 32'h0000_0000, 4'hf);
    `CHK({rd[13:12], rd[0]}, 3'b100)
    uw(1'b0, 8'h46, 8'h57, 8'h01);
    bus(1'b0, 4'h0, 32'h0000_0000, 4'hf);
    `CHK({rd[13:12], rd[0]}, 3'b100)
    groupReady <= 4'h0;
    uw(1'b1, 8'h78, 8'h9a, {v[3:2], 2'b00, v[1:0], 2'b11});
    watchdogFuse <= 1'b1;
    uw(1'b0, 8'h46, 8'h57, 8'h01);
    w = watchdogClkEnable;
    oscFail <= 1'b1;
    @(posedge ref_clk);
    oscFail <= 1'b0;
    repeat (4) @(posedge ref_clk);
    `CHK(sysClkGroup, 2'b01)
    `CHK({w, watchdogClkEnable}, 2'b11)
    `CHK(masterClearOeN, 1'b1)
    bus(1'b0, 4'h0, 32'h0000_0000, 4'hf);
    `CHK({rd[13:12], rd[3], rd[0]}, 4'b0110)
    watchdogFuse <= 1'b0;
    sleepMode <= 1'b1;
    repeat (2) @(posedge ref_clk);
    `CHK(lowRcEnable, 1'b0)
    watchdogFuse <= 1'b1;
    repeat (2) @(posedge ref_clk);
    `CHK(lowRcEnable, 1'b1)
    watchdogFuse <= 1'b0;
    sleepMode <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK(lowRcEnable, 1'b1)
    $display("switch and fail-safe test done");
    masterClearN <= 1'b0;
    repeat (3) @(posedge ref_clk);
    masterClearN <= 1'b1;
    repeat (20) @(posedge ref_clk);
    `CHK(internalResetN, 1'b1)
    masterClearN <= 1'b0;
    repeat (20) @(posedge ref_clk);
    `CHK(internalResetN, 1'b0)
    brownOut <= 1'b1;
    @(posedge ref_clk);
    brownOut <= 1'b0;
    masterClearN <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK({internalResetN, sysClkGroup}, 3'b011)
    repeat (600) @(posedge ref_clk);
    `CHK({internalResetN, sysClkGroup}, 3'b101)
    $display("master clear test done");
    close_out;
  end
endmodule
`default_nettype wire
